/* mss_pkg.sv */
package mss_pkg;
    // Oscillator and transmit clock figures.
    localparam int OSC_MHZ        = 20;
    localparam int TXCLK_MHZ      = 10;
    localparam int OSC_DIV_HALF   = OSC_MHZ / TXCLK_MHZ / 2;
    // Frame positions, counted in received bits from the first bit.
    localparam int BITS_PER_BYTE  = 8;
    localparam int CMP_BYTE       = 7;
    localparam int CMP_BIT        = 4;
    localparam logic [15:0] CMP_BIT_POS = 16'((CMP_BYTE - 1) * BITS_PER_BYTE + CMP_BIT);
    localparam logic [1:0]  REJ_MIN_CLKS = 2'h2;
    localparam logic [15:0] BIT_CNT_ONE  = 16'h0001;
    // Field positions in the second data configuration word.
    localparam int CFG2_USR_LO    = 0;
    localparam int CFG2_CMP_EN    = 1;
    localparam int CFG2_CMP_MISS  = 2;
    localparam int CFG2_USR2      = 4;
    localparam int CFG2_USR3      = 5;
    localparam int CFG2_W         = 16;
    localparam logic [CFG2_W-1:0] CFG2_RST = 16'h0000;
    // Carrier extension after the last data bit, in half bit times.
    localparam logic [1:0]  CRS_HOLD_HALF = 2'h3;
endpackage : mss_pkg

/* mss_skid_buf.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-entry skid buffer; a stall by the receiver loses no word.
module mss_skid_buf import mss_pkg::*; #(
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    // Filling side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side.
    input  wire logic             out_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data
);
    initial begin
        if (WIDTH < 1) $error("WIDTH must be positive.");
    end

    logic [WIDTH-1:0] mem_r [2];
    logic             rd_r;
    logic             wr_r;
    logic [1:0]       cnt_r;

    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rd_r];

    // Pointers and fill level move on accepted words only.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_r  <= 1'b0;
            wr_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (in_valid && in_ready) wr_r <= ~wr_r;
            if (out_valid && out_ready) rd_r <= ~rd_r;
            cnt_r <= cnt_r + 2'((in_valid && in_ready) ? 1 : 0) - 2'((out_valid && out_ready) ? 1 : 0);
        end
    end

    // Storage has no reset; it is only read when counted valid.
    always_ff @(posedge sys_clk) begin
        if (in_valid && in_ready) mem_r[wr_r] <= in_data;
    end
endmodule : mss_skid_buf
`default_nettype wire

/* mss_serial_side.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE_01: User pins float until first config write.
// RULE_02: Extended bus: float until master, then drive.
// RULE_03: Transmit NRZ data valid at clock rise.
// RULE_04: Transmit enable spans whole frame.
// RULE_05: Internal codec: divide oscillator, output clock. Code holds tx_clk_oe low while bus_master is high.
// RULE_06: External codec supplies transmit clock for shifting.
// RULE_07: Master samples termination input before cycle end.
// RULE_08: Termination used only with strap high, async.
// RULE_09: Loopback indicator follows codec loopback mode.
// RULE_10: Compression asserts on match or miss.
// RULE_11: Compression selected by bits 1,2; floats until written.
// RULE_12: Compression asserts after bit 4, byte 7.
// RULE_13: Compression drops one clock after carrier ends.
// RULE_14: Reject low two receive clocks discards packet.
// RULE_15: Reject honoured up to second-to-last bit.
// RULE_16: Codec select: 0 internal, 1 external.
// RULE_17: Internal carrier: first transition, hold 1.5 bits.
// RULE_18: Extended bus clear: pins carry network function.
module mss_serial_side import mss_pkg::*; #(
    parameter int BYTE_W = 8
) (
    // Clock and reset; sys_clk doubles as the oscillator input.
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // Configuration.
    input  wire logic              cfg_wr,
    input  wire logic              cfg2_wr,
    input  wire logic [CFG2_W-1:0] cfg2_wdata,
    input  wire logic              ext_bus_opt,
    input  wire logic              ext_codec_sel,
    input  wire logic              codec_loopback,
    input  wire logic              bus_mode_strap,
    input  wire logic              bus_async,
    // Bus master cycle termination.
    input  wire logic              bus_master,
    input  wire logic              mem_cycle_active,
    input  wire logic              sync_cycle_term_in,
    output logic                   mem_cycle_done,
    // Transmit byte stream.
    input  wire logic              tx_valid,
    output logic                   tx_ready,
    input  wire logic [BYTE_W-1:0] tx_byte,
    input  wire logic              tx_last,
    // Transmit serial pins.
    input  wire logic              tx_clk_in,
    output logic                   tx_clk_out,
    output logic                   tx_clk_oe,
    output logic                   tx_data_out,
    output logic                   tx_data_oe,
    output logic                   tx_active_out,
    // Loopback pin shared with a user output.
    output logic                   loopback_ind,
    output logic                   loopback_oe,
    // Receive side.
    input  wire logic              rx_serial_clk,
    input  wire logic              rx_data_in,
    input  wire logic              carrier_in,
    input  wire logic              addr_match_table_hit,
    input  wire logic              addr_match_valid,
    input  wire logic              pkt_reject_n,
    output logic                   carrier_sense_sig,
    output logic                   rx_discard,
    // Packet compression pin.
    output logic                   pkt_compress,
    output logic                   pkt_compress_oe
);
    initial begin
        if (BYTE_W != BITS_PER_BYTE) $error("BYTE_W must be eight.");
    end

    typedef enum {MSS_IDLE, MSS_SHIFT} mss_tx_st_t;

    // Rising edge of a sampled clock level.
    function automatic logic rise(input logic now, input logic prev);
        return now & ~prev;
    endfunction

    logic              cfg_done_r;
    logic              cfg2_done_r;
    logic              master_seen_r;
    logic [CFG2_W-1:0] cfg2_r;
    logic [1:0]        div_r;
    logic              txc_int_r;
    logic              txc_prev_r;
    logic              txc_sel;
    logic              txc_rise;
    logic              rxc_prev_r;
    logic              rxc_rise;
    mss_tx_st_t        tx_st_r;
    logic [BYTE_W-1:0] sh_r;
    logic [2:0]        bit_r;
    logic              last_r;
    logic              txd_r;
    logic              txe_r;
    logic              buf_valid;
    logic [BYTE_W:0]   buf_data;
    logic              buf_take;
    logic              term_r;
    logic              rx_d_prev_r;
    logic              crs_int_r;
    logic [1:0]        crs_hold_r;
    logic              crs;
    logic              crs_prev_r;
    logic [15:0]       bit_cnt_r;
    logic              cmp_r;
    logic              cmp_drop_r;
    logic [1:0]        rej_cnt_r;
    logic              disc_r;
    logic              user_mode;

    // Stored second configuration word and the write-seen flags.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cfg_done_r    <= 1'b0;
            cfg2_done_r   <= 1'b0;
            master_seen_r <= 1'b0;
            cfg2_r        <= CFG2_RST;
        end else begin
            if (cfg_wr) cfg_done_r <= 1'b1; // [RULE_01]
            if (cfg2_wr) begin
                cfg2_r      <= cfg2_wdata;
                cfg2_done_r <= 1'b1; // [RULE_11]
            end
            if (bus_master) master_seen_r <= 1'b1; // [RULE_02]
        end
    end

    // User pins take over once the extended-bus option is set and the first config write is seen; they drive only after mastership.
    assign user_mode = cfg_done_r && ext_bus_opt; // [RULE_18]

    // Internal transmit clock: the 20 MHz system clock halved.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            div_r     <= 2'h0;
            txc_int_r <= 1'b0;
        end else if (div_r == 2'(OSC_DIV_HALF - 1)) begin
            div_r     <= 2'h0;
            txc_int_r <= ~txc_int_r; // [RULE_05]
        end else begin
            div_r <= div_r + 2'h1;
        end
    end

    // The external clock arrives synchronous to sys_clk, so it is edge-detected directly.
    assign txc_sel  = ext_codec_sel ? tx_clk_in : txc_int_r; // [RULE_16] [RULE_06]
    assign txc_rise = rise(txc_sel, txc_prev_r);
    assign rxc_rise = rise(rx_serial_clk, rxc_prev_r);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            txc_prev_r <= 1'b0;
            rxc_prev_r <= 1'b0;
        end else begin
            txc_prev_r <= txc_sel;
            rxc_prev_r <= rx_serial_clk;
        end
    end

    // Byte stream passes a two-entry buffer so a stalled serializer drops nothing.
    mss_skid_buf #(.WIDTH(BYTE_W + 1)) u_buf (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   ({tx_last, tx_byte}),
        .out_ready (buf_take),
        .out_valid (buf_valid),
        .out_data  (buf_data)
    );

    // A new byte is loaded only at a bit boundary of the serial clock.
    assign buf_take = txc_rise && ((tx_st_r == MSS_IDLE) || ((bit_r == 3'h7) && !last_r));

    // Serializer: data changes on a rise and is stable at the next rise.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_st_r <= MSS_IDLE;
            sh_r    <= '0;
            bit_r   <= 3'h0;
            last_r  <= 1'b0;
            txd_r   <= 1'b0;
            txe_r   <= 1'b0;
        end else if (txc_rise) begin
            case (tx_st_r)
                MSS_IDLE: begin
                    if (buf_valid) begin
                        tx_st_r <= MSS_SHIFT;
                        txd_r   <= buf_data[0]; // [RULE_03]
                        sh_r    <= {1'b0, buf_data[BYTE_W-1:1]};
                        last_r  <= buf_data[BYTE_W];
                        bit_r   <= 3'h0;
                        txe_r   <= 1'b1; // [RULE_04]
                    end
                end
                MSS_SHIFT: begin
                    if (bit_r != 3'h7) begin
                        txd_r <= sh_r[0]; // [RULE_06]
                        sh_r  <= {1'b0, sh_r[BYTE_W-1:1]};
                        bit_r <= bit_r + 3'h1;
                    end else if (!last_r && buf_valid) begin
                        txd_r  <= buf_data[0];
                        sh_r   <= {1'b0, buf_data[BYTE_W-1:1]};
                        last_r <= buf_data[BYTE_W];
                        bit_r  <= 3'h0;
                    end else begin
                        tx_st_r <= MSS_IDLE;
                        txd_r   <= 1'b0;
                        txe_r   <= 1'b0; // [RULE_04]
                    end
                end
                default: tx_st_r <= MSS_IDLE;
            endcase
        end
    end

    // Termination is sampled on a clock edge, only while mastering with the strap high on an async bus.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) term_r <= 1'b0;
        else term_r <= bus_master && mem_cycle_active && sync_cycle_term_in
                       && bus_mode_strap && bus_async; // [RULE_07] [RULE_08]
    end
    assign mem_cycle_done = term_r;

    // Internal carrier: starts on the first high-to-low of data, held three half bits after the last.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_d_prev_r <= 1'b1;
            crs_int_r   <= 1'b0;
            crs_hold_r  <= 2'h0;
        end else begin
            rx_d_prev_r <= rx_data_in;
            if (carrier_in) begin
                crs_hold_r <= CRS_HOLD_HALF;
                if (rx_d_prev_r && !rx_data_in) crs_int_r <= 1'b1; // [RULE_17]
            end else if (txc_int_r != txc_prev_r || ext_codec_sel) begin
                if (crs_hold_r != 2'h0) crs_hold_r <= crs_hold_r - 2'h1;
                else crs_int_r <= 1'b0; // [RULE_17]
            end
        end
    end
    assign crs = ext_codec_sel ? carrier_in : crs_int_r; // [RULE_16]
    assign carrier_sense_sig = crs;

    // Compression and reject tracking, counted in receive bits.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            crs_prev_r <= 1'b0;
            bit_cnt_r  <= 16'h0000;
            cmp_r      <= 1'b0;
            cmp_drop_r <= 1'b0;
            rej_cnt_r  <= 2'h0;
            disc_r     <= 1'b0;
        end else begin
            crs_prev_r <= crs;
            if (crs && !crs_prev_r) begin
                bit_cnt_r <= 16'h0000;
                rej_cnt_r <= 2'h0;
                disc_r    <= 1'b0;
            end else if (crs && rxc_rise) begin
                bit_cnt_r <= bit_cnt_r + BIT_CNT_ONE;
                // Reject is honoured while carrier lasts, which covers the second-to-last bit.
                if (!pkt_reject_n) begin
                    if (rej_cnt_r != REJ_MIN_CLKS) rej_cnt_r <= rej_cnt_r + 2'h1;
                    if (rej_cnt_r + 2'h1 >= REJ_MIN_CLKS) disc_r <= 1'b1; // [RULE_14] [RULE_15]
                end else begin
                    rej_cnt_r <= 2'h0;
                end
                if (bit_cnt_r == CMP_BIT_POS - BIT_CNT_ONE && addr_match_valid && cfg2_r[CFG2_CMP_EN]
                    && (addr_match_table_hit != cfg2_r[CFG2_CMP_MISS])) begin
                    cmp_r <= 1'b1; // [RULE_10] [RULE_12]
                end
            end
            // Drop one transmit clock after carrier falls.
            if (!crs && crs_prev_r && cmp_r) cmp_drop_r <= 1'b1;
            else if (cmp_drop_r && txc_rise) begin
                cmp_drop_r <= 1'b0;
                cmp_r      <= 1'b0; // [RULE_13]
            end
        end
    end
    assign rx_discard = disc_r;

    // Pin multiplexing between network function and user outputs.
    always_comb begin
        if (user_mode) begin
            tx_data_out  = cfg2_r[CFG2_USR3]; // [RULE_02]
            tx_data_oe   = master_seen_r;
            loopback_ind = cfg2_r[CFG2_USR2];
            loopback_oe  = master_seen_r;
            tx_clk_out   = 1'b0;
            tx_clk_oe    = 1'b0;
        end else begin
            tx_data_out  = txd_r; // [RULE_18]
            tx_data_oe   = cfg_done_r; // [RULE_01]
            loopback_ind = codec_loopback; // [RULE_09]
            loopback_oe  = cfg_done_r;
            tx_clk_out   = txc_int_r; // [RULE_05]
            tx_clk_oe    = cfg_done_r && !ext_codec_sel && !bus_master;
        end
    end

    assign tx_active_out   = txe_r;
    assign pkt_compress    = cmp_r;
    assign pkt_compress_oe = cfg2_done_r; // [RULE_11]
endmodule : mss_serial_side
`default_nettype wire

/* mss_serial_side_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checker for the serial-side block.
module mss_serial_side_chk import mss_pkg::*; (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Configuration and bus inputs.
    input wire logic cfg_wr,
    input wire logic cfg2_wr,
    input wire logic ext_bus_opt,
    input wire logic codec_loopback,
    input wire logic ext_codec_sel,
    input wire logic carrier_in,
    input wire logic bus_mode_strap,
    input wire logic bus_async,
    input wire logic bus_master,
    input wire logic mem_cycle_active,
    input wire logic sync_cycle_term_in,
    input wire logic mem_cycle_done,
    // Pins.
    input wire logic tx_clk_out,
    input wire logic tx_clk_oe,
    input wire logic tx_data_oe,
    input wire logic loopback_ind,
    input wire logic loopback_oe,
    input wire logic carrier_sense_sig,
    input wire logic pkt_compress,
    input wire logic pkt_compress_oe
);
    logic cfg_seen_r, cfg2_seen_r, master_seen_r, term_ok;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Termination only counts with every qualifier present.
    assign term_ok = bus_master && mem_cycle_active && sync_cycle_term_in && bus_mode_strap && bus_async;
    // Remember first writes and mastership since reset.
    always_ff @(posedge sys_clk) begin
        cfg_seen_r    <= !sys_rst && (cfg_seen_r || cfg_wr);
        cfg2_seen_r   <= !sys_rst && (cfg2_seen_r || cfg2_wr);
        master_seen_r <= !sys_rst && (master_seen_r || bus_master);
    end
    a_cfg_float_pins: assert property (!cfg_seen_r && !cfg_wr |-> !tx_clk_oe && !tx_data_oe && !loopback_oe)
        else $error("pin driven before first config write");
    a_cmp_float_oe: assert property (!cfg2_seen_r && !cfg2_wr |-> !pkt_compress_oe)
        else $error("compression pin driven before write");
    a_user_pin_float: assert property (ext_bus_opt && $past(ext_bus_opt) && !master_seen_r && !bus_master |-> !tx_data_oe && !loopback_oe)
        else $error("user pin driven before mastership");
    a_txclk_div_two: assert property (tx_clk_oe && $past(tx_clk_oe) |-> tx_clk_out != $past(tx_clk_out))
        else $error("transmit clock not divided by two");
    a_loopback_follow: assert property (loopback_oe && !ext_bus_opt && $past(codec_loopback) == codec_loopback
        && $past(codec_loopback, 2) == codec_loopback |-> loopback_ind == codec_loopback)
        else $error("loopback indicator wrong");
    a_term_done_next: assert property ($rose(term_ok) |=> mem_cycle_done)
        else $error("termination not honoured");
    a_term_gate_only: assert property (mem_cycle_done |-> $past(term_ok))
        else $error("cycle ended without qualified termination");
    a_cmp_release_end: assert property ($fell(carrier_sense_sig) |-> ##[1:24] !pkt_compress)
        else $error("compression held after carrier end");
    // The internal carrier may only outlast the line by its short hold, never indefinitely.
    a_crs_hold_end: assert property ((!ext_codec_sel && !carrier_in) [*5] |-> !carrier_sense_sig)
        else $error("internal carrier held too long");
endmodule // mss_serial_side_chk
bind mss_serial_side mss_serial_side_chk u_chk (.*);
`default_nettype wire

/* mss_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
// Far-side codec and repeater controller; outputs change on the rising edge.
module mss_far_end import mss_pkg::*; (
    // Clock.
    input  wire logic sys_clk,
    // Lines toward the block.
    output logic      tx_clk_in,
    output logic      rx_serial_clk,
    output logic      rx_data_in,
    output logic      carrier_in,
    output logic      addr_match_table_hit,
    output logic      addr_match_valid,
    output logic      pkt_reject_n
);
    logic [1:0] div_r = 2'h0;
    int         rises = 0;
    // Idle levels; reject is pulled up.
    initial begin
        {tx_clk_in, rx_serial_clk, rx_data_in, carrier_in} = 4'h0;
        {addr_match_table_hit, addr_match_valid, pkt_reject_n} = 3'h1;
    end
    // The encoder clock runs free at an eighth of sys_clk, slow enough to be sampled.
    always @(posedge sys_clk) begin
        div_r <= div_r + 2'h1;
        if (div_r == 2'h3) tx_clk_in <= ~tx_clk_in;
    end
    // One 64-bit frame; the receive clock only runs inside it.
    task automatic frame(input logic hit, input int at, input int len);
        carrier_in           <= 1'b1;
        addr_match_table_hit <= hit;
        for (int i = 1; i <= 64; i++) begin
            @(posedge sys_clk);
            rx_serial_clk    <= 1'b0;
            rx_data_in       <= i[0];
            pkt_reject_n     <= !(i >= at && i < at + len);
            addr_match_valid <= (i >= int'(CMP_BIT_POS) - 4);
            repeat (4) @(posedge sys_clk);
            rx_serial_clk <= 1'b1;
            rises         <= i;
            repeat (3) @(posedge sys_clk);
        end
        @(posedge sys_clk);
        {rx_serial_clk, carrier_in, addr_match_valid, pkt_reject_n} <= 4'h1;
        addr_match_table_hit <= !hit;
    endtask
endmodule // mss_far_end
`default_nettype wire

/* test_mss_serial_side.sv */
`timescale 1ns/1ps
`default_nettype none
// Sequence tests for the serial-side block against the far-side model.
module test_mss_serial_side import mss_pkg::*;;
    logic sys_clk = 1'b0, sys_rst = 1'b1;
    logic cfg_wr, cfg2_wr, ext_bus_opt, ext_codec_sel, codec_loopback, bus_mode_strap, bus_async;
    logic bus_master, mem_cycle_active, sync_cycle_term_in, mem_cycle_done, tx_valid, tx_ready, tx_last;
    logic [15:0] cfg2_wdata;
    logic [7:0]  tx_byte;
    logic tx_clk_in, tx_clk_out, tx_clk_oe, tx_data_out, tx_data_oe, tx_active_out, loopback_ind, loopback_oe;
    logic rx_serial_clk, rx_data_in, carrier_in, addr_match_table_hit, addr_match_valid, pkt_reject_n;
    logic carrier_sense_sig, rx_discard, pkt_compress, pkt_compress_oe, rc, rc_prev = 1'b0;
    logic bits[$];
    int   error_cnt = 0, tests_run = 0, cycles = 0, first_cmp = 0;
    // Frame table: config word, address hit, reject start and length, expected results.
    logic [15:0] cfgv[4] = '{16'h0002, 16'h0006, 16'h0006, 16'h0000};
    int          rej_at[4] = '{10, 10, 62, 99};
    int          rej_len[4] = '{1, 2, 2, 0};
    logic [3:0]  hitv = 4'b1011, expc = 4'b0101, disc = 4'b0110;

    mss_serial_side dut (.*);
    mss_far_end far (.*);

    always #12.5 sys_clk = ~sys_clk;

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr2(input logic [15:0] d);
        cfg2_wr    <= 1'b1;
        cfg2_wdata <= d;
        cyc(1);
        cfg2_wr <= 1'b0;
    endtask
    // Sends bytes holding each until accepted, then rebuilds them from the wire, first bit lowest.
    task automatic tx_frame(input logic [23:0] d, input int n);
        logic [7:0] got;
        bits.delete();
        for (int i = 0; i < n; i++) begin
            tx_valid <= 1'b1;
            tx_byte  <= d[8*i+:8];
            tx_last  <= (i == n - 1);
            @(negedge sys_clk);
            while (tx_ready !== 1'b1) @(negedge sys_clk);
            @(posedge sys_clk);
        end
        tx_valid <= 1'b0;
        for (int t = 0; t < 900 && !(bits.size() > 0 && tx_active_out === 1'b0); t++) @(negedge sys_clk);
        chk_byte(8'(bits.size()), 8'(8 * n));
        for (int i = 0; i < n; i++) begin
            for (int j = 0; j < 8; j++) got[j] = bits[8*i+j];
            chk_byte(got, d[8*i+:8]);
        end
        cyc(1);
    endtask
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Sample wire bits at each rise of the active transmit clock; watch compression timing.
    always @(negedge sys_clk) begin
        rc = ext_codec_sel ? tx_clk_in : tx_clk_out;
        if (rc === 1'b1 && rc_prev === 1'b0 && tx_active_out === 1'b1) bits.push_back(tx_data_out);
        rc_prev = rc;
        if (pkt_compress === 1'b1 && first_cmp == 0) first_cmp = far.rises;
    end
    // A hang counts as a mismatch.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 10000) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        {cfg_wr, cfg2_wr, ext_bus_opt, ext_codec_sel, codec_loopback, bus_mode_strap} = '0;
        {bus_async, bus_master, mem_cycle_active, sync_cycle_term_in, tx_valid, tx_last} = '0;
        cfg2_wdata = '0;
        tx_byte = '0;
        cyc(2);
        sys_rst <= 1'b0;
        cyc(2);
        @(negedge sys_clk);
        chk_bit(tx_data_oe | loopback_oe | tx_clk_oe | pkt_compress_oe, 1'b0);
        cyc(1);
        cfg_wr <= 1'b1;
        cyc(1);
        cfg_wr <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            codec_loopback <= i[0];
            cyc(4);
            @(negedge sys_clk);
            chk_bit(loopback_oe & tx_clk_oe, 1'b1);
            chk_bit(loopback_ind, i[0]);
            cyc(1);
        end
        for (int k = 0; k < 6; k++) begin
            {bus_master, mem_cycle_active, bus_mode_strap, bus_async, sync_cycle_term_in} <= 5'h1f & ~(5'h1 << k);
            cyc(1);
            {bus_master, mem_cycle_active, bus_mode_strap, bus_async, sync_cycle_term_in} <= 5'h00;
            @(negedge sys_clk);
            chk_bit(mem_cycle_done, k == 5);
            cyc(2);
        end
        tx_frame(24'hff3ca5, 3);
        ext_codec_sel <= 1'b1;
        tx_frame(24'h008001, 2);
        for (int f = 0; f < 4; f++) begin
            wr2(cfgv[f]);
            first_cmp = 0;
            far.frame(hitv[f], rej_at[f], rej_len[f]);
            cyc(40);
            @(negedge sys_clk);
            chk_byte(8'(first_cmp), expc[f] ? 8'(CMP_BIT_POS) : 8'h00);
            chk_bit(pkt_compress_oe & ~pkt_compress, 1'b1);
            chk_bit(rx_discard, disc[f]);
            cyc(1);
        end
        // Internal codec: carrier follows the data and ends shortly after the line goes quiet.
        ext_codec_sel <= 1'b0;
        far.frame(1'b0, 99, 0);
        cyc(10);
        @(negedge sys_clk);
        chk_bit(carrier_sense_sig, 1'b0);
        cyc(1);
        sys_rst     <= 1'b1;
        ext_bus_opt <= 1'b1;
        cyc(2);
        sys_rst <= 1'b0;
        cfg_wr  <= 1'b1;
        cyc(1);
        cfg_wr <= 1'b0;
        wr2(16'h0030);
        cyc(3);
        @(negedge sys_clk);
        chk_bit(tx_data_oe | loopback_oe, 1'b0);
        cyc(1);
        bus_master <= 1'b1;
        cyc(1);
        bus_master <= 1'b0;
        cyc(3);
        @(negedge sys_clk);
        chk_bit(tx_data_oe & loopback_oe & tx_data_out & loopback_ind, 1'b1);
        cyc(1);
        wr2(16'h0000);
        cyc(3);
        @(negedge sys_clk);
        chk_bit(tx_data_out | loopback_ind, 1'b0);
        complete_run();
    end
endmodule // test_mss_serial_side
`default_nettype wire
